// [acs_sequencer.v]
// Conversion sequencer of a 10-bit successive-approximation converter.
// Assumes CPU-side register logic supplies control bits as ports and pulses for writes.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.vh"
module acs_sequencer #(
  parameter CHAN_W = `ACS_CHAN_W,
  parameter REF_W  = `ACS_REF_W,
  parameter RES_W  = `ACS_RES_W,
  parameter TRIG_W = `ACS_TRIG_W
) (
  // Clock and reset.
  input  wire                 I_CLOCK,
  input  wire                 I_RESET_N,
  // Control bits.
  input  wire                 I_POWER_REDUCE,
  input  wire                 I_CONVERTER_ENABLE,
  input  wire                 I_AUTO_TRIGGER_ENABLE,
  input  wire [`ACS_PS_W-1:0] I_PRESCALER_SELECT,
  input  wire [TRIG_W-1:0]    I_TRIGGER_SOURCE_SELECT,
  input  wire [CHAN_W-1:0]    I_CHANNEL_SELECT_BITS,
  input  wire [REF_W-1:0]     I_REFERENCE_SELECT_BITS,
  // Write and read strobes from the CPU side, one cycle each.
  input  wire                 I_START_WRITE,
  input  wire                 I_FLAG_CLEAR_WRITE,
  input  wire                 I_INTERRUPT_SERVICED,
  input  wire                 I_RESULT_LOW_READ,
  input  wire                 I_RESULT_HIGH_READ,
  // Trigger sources, one bit per select code, from outside the clock domain.
  input  wire [(1<<TRIG_W)-1:0] I_TRIGGER_SOURCES,
  // Result of the analog core at the end of a conversion.
  input  wire [RES_W-1:0]     I_CORE_RESULT,
  // Status.
  output reg                  O_CONVERSION_START_BIT,
  output reg                  O_CONVERSION_COMPLETE_FLAG,
  output reg  [RES_W-1:0]     O_RESULT,
  // Analog core control.
  output reg                  O_CONVERTER_CLOCK,
  output reg                  O_SAMPLE_HOLD,
  output reg  [CHAN_W-1:0]    O_ACTIVE_CHANNEL,
  output reg  [REF_W-1:0]     O_ACTIVE_REFERENCE
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_CONV = 2'd2;
  localparam NT      = 1 << TRIG_W;

  // ==========================================================
  // Trigger synchronisers
  // Three flops per source; a change counts once the last two agree.
  reg  [NT-1:0] sync1_reg;
  reg  [NT-1:0] sync2_reg;
  reg  [NT-1:0] sync3_reg;
  reg  [NT-1:0] trig_level_reg;
  genvar g;
  generate
    for (g = 0; g < NT; g = g + 1) begin : g_sync
      always @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          sync1_reg[g]      <= 1'b0;
          sync2_reg[g]      <= 1'b0;
          sync3_reg[g]      <= 1'b0;
          trig_level_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= I_TRIGGER_SOURCES[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            trig_level_reg[g] <= sync3_reg[g];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Sequencer
  reg  [1:0] state_reg;
  reg        first_reg;
  reg  [4:0] cyc_next;
  reg        auto_conv_reg;
  reg  [4:0] cyc_reg;
  reg        trig_prev_reg;
  reg        block_reg;
  reg        restart_reg;
  wire       running;
  wire       trig_sel;
  wire       freerun;
  wire       trig_edge;
  wire       ck_rise;
  wire       ck_fall;
  wire       ck_level;
  wire [4:0] conv_len;
  wire [4:0] sh_point;
  wire       last_cyc;
  wire       conv_end;

  // ==========================================================
  // Selection
  // The select code for the completion flag makes the trigger level the flag itself.
  assign freerun   = I_AUTO_TRIGGER_ENABLE && (I_TRIGGER_SOURCE_SELECT == `ACS_TRIG_FREERUN);
  assign trig_sel  = freerun ? O_CONVERSION_COMPLETE_FLAG : trig_level_reg[I_TRIGGER_SOURCE_SELECT];
  assign trig_edge = trig_sel && !trig_prev_reg;
  assign running   = I_CONVERTER_ENABLE && !I_POWER_REDUCE;
  assign conv_len  = first_reg ? `ACS_FIRST_CYC : `ACS_NORMAL_CYC;
  assign sh_point  = auto_conv_reg ? `ACS_AUTO_SH : (first_reg ? `ACS_FIRST_SH : `ACS_NORMAL_SH);
  assign last_cyc  = running && (state_reg == ST_CONV) && (cyc_reg == conv_len - 5'd1);
  assign conv_end  = last_cyc && ck_rise;

  acs_prescaler #(
    .PS_W (`ACS_PS_W)
  ) u_prescaler (
    .i_clk     (I_CLOCK),
    .i_reset_n (I_RESET_N),
    .i_enable  (running),
    .i_restart (restart_reg),
    .i_sel     (I_PRESCALER_SELECT),
    .o_rise    (ck_rise),
    .o_fall    (ck_fall),
    .o_level   (ck_level)
  );

  // ==========================================================
  // Converter cycle counter
  always @* begin
    cyc_next = cyc_reg;
    if (state_reg == ST_WAIT && ck_rise && !restart_reg) begin
      cyc_next = 5'd0;
    end else if (state_reg == ST_CONV && ck_rise) begin
      if (conv_end && freerun) begin
        cyc_next = 5'd0;
      end else begin
        cyc_next = cyc_reg + 5'd1;
      end
    end
  end

  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cyc_reg <= 5'd0;
    end else begin
      cyc_reg <= cyc_next;
    end
  end

  // ==========================================================
  // Trigger edge detector
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= trig_sel;
    end
  end

  // ==========================================================
  // Converter clock output
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CONVERTER_CLOCK <= 1'b0;
    end else begin
      O_CONVERTER_CLOCK <= ck_level;
    end
  end

  // ==========================================================
  // First-conversion marker
  // Every disable sets it again, so the slow initialising conversion follows each enable.
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      first_reg <= 1'b1;
    end else if (!running) begin
      first_reg <= 1'b1;
    end else if (conv_end) begin
      first_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Completion flag
  // A completion that meets a clear in one cycle keeps the flag, so no event is lost.
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CONVERSION_COMPLETE_FLAG <= 1'b0;
    end else if (conv_end) begin
      O_CONVERSION_COMPLETE_FLAG <= 1'b1;
    end else if (I_FLAG_CLEAR_WRITE || I_INTERRUPT_SERVICED) begin
      O_CONVERSION_COMPLETE_FLAG <= 1'b0;
    end
  end

  // ==========================================================
  // Result register and read lock
  // A result completing while the lock is on is lost unless the high read comes in that same cycle; the flag still rises.
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      block_reg <= 1'b0;
      O_RESULT  <= {RES_W{1'b0}};
    end else begin
      if (I_RESULT_HIGH_READ) begin
        block_reg <= 1'b0;
      end else if (I_RESULT_LOW_READ) begin
        block_reg <= 1'b1;
      end
      if (conv_end && (!block_reg || I_RESULT_HIGH_READ)) begin
        O_RESULT <= I_CORE_RESULT;
      end
    end
  end

  // ==========================================================
  // Shadow copy of channel and reference
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ACTIVE_CHANNEL   <= `ACS_CHAN_RST;
      O_ACTIVE_REFERENCE <= `ACS_REF_RST;
    end else if (running && (state_reg != ST_CONV || last_cyc)) begin
      O_ACTIVE_CHANNEL   <= I_CHANNEL_SELECT_BITS;
      O_ACTIVE_REFERENCE <= I_REFERENCE_SELECT_BITS;
    end
  end

  // ==========================================================
  // Sample-and-hold strobe
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SAMPLE_HOLD <= 1'b0;
    end else begin
      O_SAMPLE_HOLD <= running && (state_reg == ST_CONV) && ck_fall && (cyc_reg == sh_point);
    end
  end

  // ==========================================================
  // Conversion state
  always @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg              <= ST_IDLE;
      auto_conv_reg          <= 1'b0;
      restart_reg            <= 1'b0;
      O_CONVERSION_START_BIT <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (!running) begin
        state_reg              <= ST_IDLE;
        O_CONVERSION_START_BIT <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (I_START_WRITE) begin
              O_CONVERSION_START_BIT <= 1'b1;
              auto_conv_reg          <= 1'b0;
              state_reg              <= ST_WAIT;
            end else if (I_AUTO_TRIGGER_ENABLE && trig_edge && !freerun) begin
              O_CONVERSION_START_BIT <= 1'b1;
              auto_conv_reg          <= 1'b1;
              restart_reg            <= 1'b1;
              state_reg              <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (ck_rise && !restart_reg) begin
              state_reg <= ST_CONV;
            end
          end
          ST_CONV: begin
            // Trigger edges seen here are dropped on purpose.
            if (conv_end && freerun) begin
              auto_conv_reg <= 1'b0;
            end else if (conv_end) begin
              O_CONVERSION_START_BIT <= 1'b0;
              state_reg              <= ST_IDLE;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [acs_regs.vh]
// Constants of the conversion sequencer: field widths, reset values, timing counts.
// Included by the sequencer and its prescaler; holds definitions only.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_CHAN_W        4
`define ACS_REF_W         2
`define ACS_PS_W          3
`define ACS_TRIG_W        3
`define ACS_RES_W         10
`define ACS_NORMAL_CYC    5'd13
`define ACS_FIRST_CYC     5'd25
`define ACS_NORMAL_SH     5'd1
`define ACS_FIRST_SH      5'd13
`define ACS_AUTO_SH       5'd2
`define ACS_CHAN_RST      4'h0
`define ACS_REF_RST       2'h0
`define ACS_CLK_HZ        10000000
`define ACS_MIN_CPU_HZ    100000
`define ACS_TRIG_FREERUN  3'h0
`endif

// [acs_prescaler.v]
// Converter clock prescaler: divides the CPU clock by 2**(sel+1).
// Assumes the sequencer drives a synchronous restart and an enable.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.vh"
module acs_prescaler #(
  parameter PS_W = `ACS_PS_W
) (
  // Clock and reset.
  input  wire            i_clk,
  input  wire            i_reset_n,
  // Control.
  input  wire            i_enable,
  input  wire            i_restart,
  input  wire [PS_W-1:0] i_sel,
  // Rising- and falling-edge strobes of the converter clock, and its level.
  output reg             o_rise,
  output reg             o_fall,
  output reg             o_level
);
  reg  [7:0] cnt_reg;
  wire [7:0] half;
  wire [7:0] full;
  assign half = 8'h01 << i_sel;
  assign full = 8'h02 << i_sel;
  // ==========================================================
  // Divider
  // Held cleared while disabled so counting starts on enable.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 8'h00;
      o_rise  <= 1'b0;
      o_fall  <= 1'b0;
      o_level <= 1'b0;
    end else if (!i_enable || i_restart) begin
      cnt_reg <= 8'h00;
      o_rise  <= 1'b0;
      o_fall  <= 1'b0;
      o_level <= 1'b0;
    end else begin
      // A select change that leaves the count past the new end wraps at once instead of stalling.
      o_rise <= (cnt_reg >= full - 8'h01);
      o_fall <= (cnt_reg == half - 8'h01);
      if (cnt_reg >= full - 8'h01) begin
        cnt_reg <= 8'h00;
        o_level <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == half - 8'h01) begin
          o_level <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [acs_seq_monitor.sv]
// Checker of the conversion sequencer, bound to its ports.
// Assumes default field widths and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module acs_seq_monitor (
  // Clock and reset.
  input wire       I_CLOCK,
  input wire       I_RESET_N,
  // Controls.
  input wire       I_POWER_REDUCE,
  input wire       I_CONVERTER_ENABLE,
  input wire [3:0] I_CHANNEL_SELECT_BITS,
  input wire       I_START_WRITE,
  input wire       I_FLAG_CLEAR_WRITE,
  input wire       I_INTERRUPT_SERVICED,
  // Status.
  input wire       O_CONVERSION_START_BIT,
  input wire       O_CONVERSION_COMPLETE_FLAG,
  input wire       O_CONVERTER_CLOCK,
  input wire       O_SAMPLE_HOLD,
  input wire [3:0] O_ACTIVE_CHANNEL
);
  wire sb = O_CONVERSION_START_BIT;
  wire fl = O_CONVERSION_COMPLETE_FLAG;
  wire on = I_CONVERTER_ENABLE && !I_POWER_REDUCE;
  // ==========================================
  // Properties.
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  property p_start; on && I_START_WRITE && !sb |=> sb; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_block; I_POWER_REDUCE && !sb |=> !sb; endproperty
  a_block: assert property (p_block) else $error("start while power reduced");
  property p_done; $fell(sb) && on |-> fl; endproperty
  a_done: assert property (p_done) else $error("start bit fell without flag");
  property p_keep; fl && I_CONVERTER_ENABLE && !I_FLAG_CLEAR_WRITE && !I_INTERRUPT_SERVICED |=> fl; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_clear; (I_FLAG_CLEAR_WRITE || I_INTERRUPT_SERVICED) && !sb |=> !fl; endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_sample; O_SAMPLE_HOLD |-> sb ##1 !O_SAMPLE_HOLD; endproperty
  a_sample: assert property (p_sample) else $error("bad sample pulse");
  property p_off; !I_CONVERTER_ENABLE [*3] |-> !O_CONVERTER_CLOCK && !sb; endproperty
  a_off: assert property (p_off) else $error("active while disabled");
  property p_copy; on && !sb && !I_START_WRITE |=> O_ACTIVE_CHANNEL == $past(I_CHANNEL_SELECT_BITS); endproperty
  a_copy: assert property (p_copy) else $error("shadow not following");
endmodule
bind acs_sequencer acs_seq_monitor u_mon (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N),
  .I_POWER_REDUCE(I_POWER_REDUCE), .I_CONVERTER_ENABLE(I_CONVERTER_ENABLE),
  .I_CHANNEL_SELECT_BITS(I_CHANNEL_SELECT_BITS), .I_START_WRITE(I_START_WRITE),
  .I_FLAG_CLEAR_WRITE(I_FLAG_CLEAR_WRITE), .I_INTERRUPT_SERVICED(I_INTERRUPT_SERVICED),
  .O_CONVERSION_START_BIT(O_CONVERSION_START_BIT), .O_CONVERSION_COMPLETE_FLAG(O_CONVERSION_COMPLETE_FLAG),
  .O_CONVERTER_CLOCK(O_CONVERTER_CLOCK), .O_SAMPLE_HOLD(O_SAMPLE_HOLD), .O_ACTIVE_CHANNEL(O_ACTIVE_CHANNEL));
`default_nettype wire

// [acs_core_model.sv]
// Model of the analog core and the trigger sources.
// Assumes the bench names a trigger code for one cycle.
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
  // Clock and bench request.
  input  wire logic       i_clk,
  input  wire logic [2:0] i_fire,
  // Sequencer side.
  input  wire logic       i_sh,
  input  wire logic [3:0] i_chan,
  input  wire logic [1:0] i_ref,
  output var  logic [7:0] o_trig,
  output var  logic [9:0] o_res
);
  int hold = 0;
  initial o_trig = 8'h00;
  initial o_res = 10'h000;
  // The result names what was sampled, so a wrong channel shows up.
  always @(posedge i_clk) if (i_sh) o_res <= {4'h5, i_ref, i_chan};
  // A trigger outlives its conversion, so a level still high must not restart.
  always @(posedge i_clk) begin
    hold <= (i_fire != 3'h0) ? 60 : (hold > 0 ? hold - 1 : 0);
    if (i_fire != 3'h0) o_trig <= 8'h01 << i_fire;
    else if (hold == 1) o_trig <= 8'h00;
  end
endmodule
`default_nettype wire

// [acs_sequencer_bench.sv]
// Self-checking bench of the conversion sequencer with its core model.
// Assumes default widths; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_bench;
  typedef struct {logic [9:0] r; int lo; int hi; int t0;} acs_note_t;
  logic clk, rst_n, pwr, en, aut, st, clr, svc, lrd, hrd, sb, fl, cck, sh;
  logic [2:0] ps, ts, fire;
  logic [3:0] ch, ach, chb;
  logic [1:0] rf, arf;
  logic [7:0] trig;
  logic [9:0] core, res, lastr;
  int miscompares, n_compared, cyc, last, d;
  acs_note_t q[$];
  acs_sequencer dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_POWER_REDUCE(pwr), .I_CONVERTER_ENABLE(en),
    .I_AUTO_TRIGGER_ENABLE(aut), .I_PRESCALER_SELECT(ps), .I_TRIGGER_SOURCE_SELECT(ts),
    .I_CHANNEL_SELECT_BITS(ch), .I_REFERENCE_SELECT_BITS(rf), .I_START_WRITE(st), .I_FLAG_CLEAR_WRITE(clr),
    .I_INTERRUPT_SERVICED(svc), .I_RESULT_LOW_READ(lrd), .I_RESULT_HIGH_READ(hrd), .I_TRIGGER_SOURCES(trig),
    .I_CORE_RESULT(core), .O_CONVERSION_START_BIT(sb), .O_CONVERSION_COMPLETE_FLAG(fl), .O_RESULT(res),
    .O_CONVERTER_CLOCK(cck), .O_SAMPLE_HOLD(sh), .O_ACTIVE_CHANNEL(ach), .O_ACTIVE_REFERENCE(arf));
  acs_core_model model (.i_clk(clk), .i_fire(fire), .i_sh(sh), .i_chan(ach), .i_ref(arf), .o_trig(trig),
    .o_res(core));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // The run needs about two thousand cycles; the ceiling leaves ample room.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================
  // Tasks.
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp_v(string nm, logic [9:0] e, logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_t(string nm, int lo, int hi, int g);
    n_compared++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("mismatch %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic go(int lo, int hi, bit blk = 0);
    if (!blk) lastr = {4'h5, rf, ch};
    q.push_back('{lastr, lo, hi, cyc});
    st = 1;
    tick(1);
    st = 0;
    tick(1);
    cmp_v("start bit", 1, sb);
  endtask
  task automatic done(bit s);
    for (int i = 0; i < 3000 && fl !== 1'b1; i++) tick(1);
    cmp_v("start bit", s, sb);
  endtask
  task automatic ack(bit s);
    svc = s;
    clr = !s;
    tick(1);
    {svc, clr} = 2'b00;
    tick(1);
    cmp_v("flag", 0, fl);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Each completion takes the oldest note; a negative start means since the last completion.
  initial begin
    acs_note_t n;
    forever begin
      @(posedge fl);
      #2;
      cmp_t("pending notes", 1, 9, q.size());
      if (q.size() > 0) begin
        n = q.pop_front();
        cmp_v("result", n.r, res);
        cmp_t("cycles", n.lo, n.hi, cyc - (n.t0 < 0 ? last : n.t0));
      end
      last = cyc;
    end
  end
  initial begin
    {pwr, en, aut, st, clr, svc, lrd, hrd} = 8'h80;
    {ps, ts, fire, ch, rf} = 15'h0000;
    rst_n = 0;
    d = $urandom(32'hCC5F);
    tick(8);
    rst_n = 1;
    en = 1;
    st = 1;
    tick(1);
    st = 0;
    tick(30);
    cmp_v("start bit", 0, sb);
    pwr = 0;
    rf = 2'($urandom());
    ch = 4'($urandom());
    tick(2);
    go(50, 56);
    tick(6);
    ch = ~ch;
    done(0);
    ack(0);
    for (int p = 0; p < 3; p++) begin
      ps = p[2:0];
      ch = 4'($urandom());
      tick(8);
      d = 2 << p;
      go(13 * d, 14 * d + 4);
      done(0);
      ack(p[0]);
    end
    ps = 3'h5;
    tick(2);
    go(832, 900);
    done(0);
    ack(0);
    ps = 3'h0;
    lrd = 1;
    tick(8);
    lrd = 0;
    go(26, 32, 1);
    done(0);
    ack(0);
    hrd = 1;
    tick(1);
    hrd = 0;
    ch = ~ch;
    tick(2);
    go(26, 32);
    done(0);
    ack(1);
    aut = 1;
    for (int c = 1; c < 8; c++) begin
      ts = c[2:0];
      ch = 4'($urandom());
      tick(2);
      q.push_back('{{4'h5, rf, ch}, 24, 40, cyc});
      fire = c[2:0];
      tick(1);
      fire = 3'h0;
      done(0);
      tick(20);
      cmp_v("start bit", 0, sb);
      tick(20);
      ack(c[0]);
    end
    go(26, 32);
    done(0);
    ack(0);
    ts = 3'h0;
    ch = 4'($urandom());
    chb = ~ch;
    tick(2);
    go(26, 32);
    q.push_back('{lastr, 25, 27, -1});
    q.push_back('{{4'h5, rf, chb}, 25, 27, -1});
    done(1);
    ch = chb;
    ack(1);
    done(1);
    ack(0);
    done(1);
    ack(1);
    en = 0;
    tick(3);
    cmp_v("start bit", 0, sb);
    tick(5);
    cmp_t("pending notes", 0, 0, q.size());
    give_verdict();
  end
endmodule
`default_nettype wire
